//--- uiec_top.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module uiec_top #(
  parameter int SLOTS = uiec_pkg::PKT_SLOTS
) (
  input  wire logic                    REF_CLK,
  input  wire logic                    RST,
  input  wire logic [7:0]              ADDR,
  input  wire logic [7:0]              WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output logic [7:0]                   RDATA,
  input  wire logic                    IN_TOKEN,
  input  wire logic                    SOF,
  input  wire logic                    TX_DONE,
  input  wire logic                    PKT_HAS_DATA,
  output logic                         RESP_VALID,
  output uiec_pkg::uiec_resp_e         RESP_KIND,
  output logic                         PKT_RELEASE,
  output logic                         FIFO_FLUSH,
  output logic                         CLR_TOGGLE,
  output logic                         IRQ
);
  import uiec_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  uiec_state_e      state_reg, state_next;
  logic             pkt_ready_reg, pkt_ready_next;
  logic             send_stall_reg, send_stall_next;
  logic             stall_sent_reg, stall_sent_next;
  logic             underrun_reg, underrun_next;
  logic             flush_reg, flush_next;
  logic             hold_reg, hold_next;
  logic [7:0]       high_reg, high_next;
  logic [IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [7:0]       rdata_reg, rdata_next;
  logic             rv_reg, rv_next, rel_reg, rel_next;
  logic             ffl_reg, ffl_next, clr_reg, clr_next;
  uiec_resp_e       kind_reg, kind_next;

  logic       wr_low, wr_high, wr_stat, wr_mask;
  logic       dbl, iso, iso_update, stall_act, ready, commit, flush_fire, tx_pop;
  logic       ev_sent, ev_stall, ev_undr, ev_flush;
  logic [1:0] count;
  logic       head_empty;
  logic [7:0] low_view;

  assign wr_low  = WR && (ADDR == OFS_CTRL_LOW);
  assign wr_high = WR && (ADDR == OFS_CTRL_HIGH);
  assign wr_stat = WR && (ADDR == OFS_IRQ_STAT);
  assign wr_mask = WR && (ADDR == OFS_IRQ_MASK);
  assign dbl        = high_reg[B_DOUBLE_BUF];
  assign iso        = high_reg[B_ISO];
  assign iso_update = high_reg[B_ISO_UPDATE];

  // Stall is ignored in isochronous mode
  assign stall_act = send_stall_reg && !iso;
  // A packet committed in iso mode under iso update waits for the next frame
  assign ready     = (count != 2'h0) && !hold_reg;
  // A commit needs a free slot; firmware waits for ready to drop first
  assign commit    = wr_low && WDATA[B_PKT_READY] && !pkt_ready_reg
                     && (count < ((dbl) ? 2'(SLOTS) : 2'h1));
  assign tx_pop    = (state_reg == ST_SEND) && TX_DONE;
  // IN tokens win over a pending flush, so the packet being answered is sent before the flush pops
  assign flush_fire = flush_reg && (state_reg == ST_IDLE) && !IN_TOKEN;
  assign low_view  = {1'b0, 1'b0, stall_sent_reg, send_stall_reg, flush_reg, underrun_reg,
                      (count != 2'h0), pkt_ready_reg && !hold_reg};

  uiec_pktq #(
    .DEPTH (SLOTS),
    .CW    (2)
  ) u_pktq (
    .clk        (REF_CLK),
    .rst        (RST),
    .push       (commit),
    .push_empty (!PKT_HAS_DATA),
    .pop        (tx_pop || (flush_fire && (count != 2'h0))),
    .count      (count),
    .head_empty (head_empty)
  );

  // ----------------------------------------
  // Token handling and control bits
  // ----------------------------------------
  always_comb begin
    state_next  = state_reg;
    kind_next   = kind_reg;
    rv_next     = 1'b0;
    rel_next    = tx_pop;
    ffl_next    = flush_fire;
    clr_next    = wr_low && WDATA[B_CLRDT];
    ev_sent     = 1'b0;
    ev_stall    = 1'b0;
    ev_undr     = 1'b0;
    ev_flush    = flush_fire && (count != 2'h0);
    unique case (state_reg)
      ST_IDLE: begin
        if (IN_TOKEN) begin
          rv_next = 1'b1;
          if (stall_act) begin
            kind_next = RESP_STALL;
            ev_stall  = 1'b1;
          end else if (ready) begin
            kind_next  = head_empty ? RESP_ZLP : RESP_DATA;
            state_next = ST_SEND;
          end else if (iso) begin
            kind_next = RESP_ZLP;
            ev_undr   = 1'b1;
          end else begin
            kind_next = RESP_NAK;
            ev_undr   = 1'b1;
          end
        end
      end
      ST_SEND: begin
        if (TX_DONE) begin
          ev_sent    = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase

    // Hardware clears ready on transmit, flush or an open double-buffer slot
    pkt_ready_next = pkt_ready_reg;
    if (tx_pop || flush_fire) begin
      pkt_ready_next = 1'b0;
    end else if (dbl && pkt_ready_reg && (count < 2'(SLOTS))) begin
      pkt_ready_next = 1'b0;
    end
    if (commit) begin
      pkt_ready_next = 1'b1;
    end

    send_stall_next = wr_low ? WDATA[B_SEND_STALL] : send_stall_reg;
    stall_sent_next = ev_stall
                      || (stall_sent_reg && !(wr_low && !WDATA[B_STALL_SENT]));
    underrun_next   = ev_undr || (underrun_reg && !(wr_low && !WDATA[B_UNDERRUN]));
    flush_next = flush_fire ? 1'b0 : (flush_reg || (wr_low && WDATA[B_FLUSH]));
    hold_next  = (commit && iso && iso_update) || (hold_reg && !SOF);
    high_next  = wr_high ? WDATA : high_reg;
    mask_next  = wr_mask ? WDATA[IRQ_W-1:0] : mask_reg;
    // A new event wins over a write-one clear in the same cycle
    stat_next  = (stat_reg & ~(wr_stat ? WDATA[IRQ_W-1:0] : RST_IRQ))
                 | {ev_flush, ev_undr, ev_stall, ev_sent};

    rdata_next = 8'h00;
    if (RD) begin
      unique case (ADDR)
        OFS_CTRL_LOW:  rdata_next = low_view;
        OFS_CTRL_HIGH: rdata_next = high_reg;
        OFS_IRQ_STAT:  rdata_next = {{(8-IRQ_W){1'b0}}, stat_reg};
        OFS_IRQ_MASK:  rdata_next = {{(8-IRQ_W){1'b0}}, mask_reg};
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg  <= ST_IDLE;
      kind_reg   <= RESP_NAK;
      rv_reg     <= 1'b0;
      rel_reg    <= 1'b0;
      ffl_reg    <= 1'b0;
      clr_reg    <= 1'b0;
      pkt_ready_reg  <= 1'b0;
      send_stall_reg <= 1'b0;
      stall_sent_reg <= 1'b0;
      underrun_reg   <= 1'b0;
      flush_reg  <= 1'b0;
      hold_reg   <= 1'b0;
      high_reg   <= RST_CTRL_HIGH;
      mask_reg   <= RST_IRQ;
      stat_reg   <= RST_IRQ;
      rdata_reg  <= 8'h00;
    end else begin
      state_reg  <= state_next;
      kind_reg   <= kind_next;
      rv_reg     <= rv_next;
      rel_reg    <= rel_next;
      ffl_reg    <= ffl_next;
      clr_reg    <= clr_next;
      pkt_ready_reg  <= pkt_ready_next;
      send_stall_reg <= send_stall_next;
      stall_sent_reg <= stall_sent_next;
      underrun_reg   <= underrun_next;
      flush_reg  <= flush_next;
      hold_reg   <= hold_next;
      high_reg   <= high_next;
      mask_reg   <= mask_next;
      stat_reg   <= stat_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign RDATA       = rdata_reg;
  assign RESP_VALID  = rv_reg;
  assign RESP_KIND   = kind_reg;
  assign PKT_RELEASE = rel_reg;
  assign FIFO_FLUSH  = ffl_reg;
  assign CLR_TOGGLE  = clr_reg;
  assign IRQ         = |(stat_reg & mask_reg);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  logic tok_idle;
  assign tok_idle = IN_TOKEN && (state_reg == ST_IDLE);

  AST_STALL_ANSWER: assert property (
    tok_idle && send_stall_reg && !iso |=> RESP_VALID && (RESP_KIND == RESP_STALL))
    else $error("stall request not answered with STALL");
  AST_STALL_ENDS: assert property (
    wr_low && !WDATA[B_SEND_STALL] ##1 tok_idle |=> RESP_VALID && (RESP_KIND != RESP_STALL))
    else $error("STALL sent after stall request cleared");
  AST_ISO_NO_STALL: assert property (
    tok_idle && iso |=> RESP_KIND != RESP_STALL)
    else $error("STALL sent in isochronous mode");
  AST_READY_CLEARED_ON_TX: assert property (
    tx_pop && !wr_low |=> !pkt_ready_reg && PKT_RELEASE)
    else $error("ready not cleared after transmit");
  AST_DB_FREE_SLOT: assert property (
    dbl && !wr_low && !wr_high ##1 commit && (count == 2'h0)
    |=> pkt_ready_reg ##1 !pkt_ready_reg)
    else $error("ready not released with open double-buffer slot");
  AST_ISO_UPDATE_ENABLE_READ_ZERO: assert property (
    RD && (ADDR == OFS_CTRL_LOW) && hold_reg |=> !RDATA[B_PKT_READY])
    else $error("ready visible before start of frame");
  AST_SENT_IRQ_CAUSE: assert property (
    $rose(stat_reg[I_SENT]) |-> $past(tx_pop))
    else $error("sent interrupt without a transmission");
  AST_STALL_FLAG: assert property (
    RESP_VALID && (RESP_KIND == RESP_STALL) |-> stall_sent_reg && stat_reg[I_STALL])
    else $error("stall sent flag missing");
  AST_ISO_UNDERRUN: assert property (
    tok_idle && iso && !ready |=> (RESP_KIND == RESP_ZLP) && underrun_reg)
    else $error("isochronous underrun not reported");
  AST_EMPTY_LOAD_ZLP: assert property (
    tok_idle && !stall_act && ready && head_empty |=> RESP_KIND == RESP_ZLP)
    else $error("empty load not sent as zero-length packet");
  AST_FLUSH_DONE: assert property (
    wr_low && WDATA[B_FLUSH] && !flush_reg && (state_reg == ST_IDLE)
    ##1 (state_reg == ST_IDLE) && !IN_TOKEN && !WR
    |=> !flush_reg && FIFO_FLUSH && !pkt_ready_reg)
    else $error("flush did not complete");

  COV_STALL: cover property (RESP_VALID && (RESP_KIND == RESP_STALL));
  COV_SEND:  cover property (tok_idle && ready ##[1:20] tx_pop);
  COV_DB2:   cover property (count == 2'h2);
  COV_ISO_UPDATE_ENABLE: cover property (hold_reg ##[1:50] SOF);
endmodule

//--- uiec_pkg.sv
// Behaviour
// - While the send-stall request bit is one, every IN token outside isochronous mode is answered with a STALL.
// - Writing zero to the send-stall request bit ends the STALL answers.
// - In isochronous mode the send-stall request bit has no effect on IN answers.
// - In-packet-ready is cleared once a packet has been transmitted to the host.
// - With double buffering and a free packet slot, in-packet-ready clears at once.
// - In isochronous mode with iso update set, in-packet-ready reads zero until next SOF.
// - Only a transmitted packet raises the sent interrupt bit, never a slot opening.
// - Each STALL sent sets the stall-sent flag and an interrupt; firmware clears it.
// - Isochronous IN token with no packet ready gives a zero-length packet and underrun.
// - Firmware loads then sets in-packet-ready; with no data loaded a zero-length packet goes.
package uiec_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL_LOW  = 8'h11;
  localparam logic [7:0] OFS_CTRL_HIGH = 8'h12;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h21;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_PKT_READY      = 0;
  localparam int B_FIFO_NOT_EMPTY = 1;
  localparam int B_UNDERRUN       = 2;
  localparam int B_FLUSH          = 3;
  localparam int B_SEND_STALL     = 4;
  localparam int B_STALL_SENT     = 5;
  localparam int B_CLRDT          = 6;
  localparam int B_DOUBLE_BUF     = 7;
  localparam int B_ISO            = 6;
  localparam int B_ISO_UPDATE     = 0;
  localparam int I_SENT   = 0;
  localparam int I_STALL  = 1;
  localparam int I_UNDR   = 2;
  localparam int I_FLUSH  = 3;
  localparam int IRQ_W    = 4;
  localparam int PKT_SLOTS = 2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]       RST_CTRL_HIGH = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ       = 4'h0;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RESP_NAK   = 2'b00,
    RESP_DATA  = 2'b01,
    RESP_ZLP   = 2'b11,
    RESP_STALL = 2'b10
  } uiec_resp_e;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } uiec_state_e;
endpackage

//--- uiec_pktq.sv
`timescale 1ns/10ps
// Committed packet queue; one flag per packet marks a zero-length load
module uiec_pktq #(
  parameter int DEPTH = 2,
  parameter int CW    = 2
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          push,
  input  wire logic          push_empty,
  input  wire logic          pop,
  output logic [CW-1:0]      count,
  output logic               head_empty
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [DEPTH-1:0] flag_reg, flag_next;
  logic [PW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0]    cnt_reg, cnt_next;

  function automatic logic [PW-1:0] wrap(input logic [PW-1:0] p);
    wrap = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_comb begin
    flag_next = flag_reg;
    wp_next   = wp_reg;
    rp_next   = rp_reg;
    cnt_next  = cnt_reg;
    if (push) begin
      flag_next[wp_reg] = push_empty;
      wp_next           = wrap(wp_reg);
    end
    if (pop) begin
      rp_next = wrap(rp_reg);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + CW'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_reg <= '0;
      wp_reg   <= '0;
      rp_reg   <= '0;
      cnt_reg  <= '0;
    end else begin
      flag_reg <= flag_next;
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign count      = cnt_reg;
  assign head_empty = flag_reg[rp_reg];
endmodule

//--- uiec_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host side: IN tokens, SOF and SIE completion
// ----------------------------------------
module uiec_host_model (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 tok_req,
  input  wire logic                 sof_req,
  input  wire logic                 ack_zlp,
  input  wire logic [3:0]           ack_delay,
  input  wire logic                 resp_valid,
  input  wire uiec_pkg::uiec_resp_e resp_kind,
  output logic                      in_token,
  output logic                      sof,
  output logic                      tx_done
);
  import uiec_pkg::*;
  logic       busy;
  logic [3:0] wait_cnt;
  // No token while busy with a packet; busy starts two cycles after the token, so a token in between gets no answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_token <= 1'b0;
      sof      <= 1'b0;
      tx_done  <= 1'b0;
      busy     <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      in_token <= tok_req && !busy;
      sof      <= sof_req;
      tx_done  <= 1'b0;
      if (resp_valid && (resp_kind == RESP_DATA || (resp_kind == RESP_ZLP && ack_zlp))) begin
        busy     <= 1'b1;
        wait_cnt <= ack_delay;
      end else if (busy && wait_cnt == 4'h0) begin
        busy    <= 1'b0;
        tx_done <= 1'b1;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule

//--- uiec_top_bench.sv
`timescale 1ns/10ps
module uiec_top_bench;
  import uiec_pkg::*;
  logic       clk, rst, wr, rd, has_data, tok_req, sof_req, ack_zlp;
  logic       in_token, sof, tx_done, resp_valid, pkt_release, fifo_flush, clr_toggle, irq;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] ack_delay;
  uiec_resp_e resp_kind;
  int         n_errors, checked, n_flush, n_clr, k;
  // ----------------------------------------
  // Clock, instances, pulse counters
  // ----------------------------------------
  always #5 clk = ~clk;
  uiec_top dut_u (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IN_TOKEN(in_token), .SOF(sof), .TX_DONE(tx_done),
    .PKT_HAS_DATA(has_data), .RESP_VALID(resp_valid), .RESP_KIND(resp_kind),
    .PKT_RELEASE(pkt_release), .FIFO_FLUSH(fifo_flush), .CLR_TOGGLE(clr_toggle), .IRQ(irq));
  uiec_host_model host_u (.clk(clk), .rst(rst), .tok_req(tok_req), .sof_req(sof_req),
    .ack_zlp(ack_zlp), .ack_delay(ack_delay), .resp_valid(resp_valid),
    .resp_kind(resp_kind), .in_token(in_token), .sof(sof), .tx_done(tx_done));
  always @(posedge clk) begin
    n_flush += (fifo_flush === 1'b1);
    n_clr += (clr_toggle === 1'b1);
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp, string name);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask
  // Waits are bounded; a lost handshake ends the run at once
  task automatic wait_hi(ref logic s, input string name);
    int i;
    for (i = 0; i < 40 && s !== 1'b1; i++) @(posedge clk) #1;
    if (s !== 1'b1) begin
      n_errors++;
      $display("Error %s expected 1 seen timeout", name);
      conclude();
    end
  endtask
  task automatic token(uiec_resp_e exp);
    @(posedge clk);
    tok_req <= 1'b1;
    @(posedge clk);
    tok_req <= 1'b0;
    wait_hi(resp_valid, "resp_valid");
    chk("resp_kind", {6'h00, exp}, {6'h00, resp_kind});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {wr, rd, has_data, tok_req, sof_req, ack_zlp} = 6'h00;
    {addr, wdata, ack_delay} = 20'h00000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_CTRL_LOW, 8'h00, "ctrl_low");
    rd_chk(OFS_CTRL_HIGH, RST_CTRL_HIGH, "ctrl_high");
    rd_chk(OFS_IRQ_STAT, 8'h00, "irq_stat");
    rd_chk(8'h30, 8'h00, "unmapped");
    wr_reg(OFS_IRQ_MASK, 8'h0f);
    token(RESP_NAK);
    rd_chk(OFS_CTRL_LOW, 8'h04, "ctrl_low");
    chk("irq", 8'h01, {7'h00, irq});
    wr_reg(OFS_IRQ_MASK, 8'h00);
    #1 chk("irq", 8'h00, {7'h00, irq});
    wr_reg(OFS_IRQ_MASK, 8'h0f);
    wr_reg(OFS_IRQ_STAT, 8'h0f);
    wr_reg(OFS_CTRL_LOW, 8'h00);
    // Loaded packet with a slow host, then an empty load with a prompt one
    for (k = 0; k < 2; k++) begin
      has_data <= (k == 0);
      ack_zlp <= (k == 1);
      ack_delay <= k ? 4'h0 : 4'h9;
      wr_reg(OFS_CTRL_LOW, 8'h01);
      rd_chk(OFS_CTRL_LOW, 8'h03, "ctrl_low");
      token(k ? RESP_ZLP : RESP_DATA);
      wait_hi(pkt_release, "pkt_release");
      rd_chk(OFS_CTRL_LOW, 8'h00, "ctrl_low");
      rd_chk(OFS_IRQ_STAT, 8'h01, "irq_stat");
      wr_reg(OFS_IRQ_STAT, 8'h01);
    end
    ack_zlp <= 1'b0;
    has_data <= 1'b1;
    wr_reg(OFS_CTRL_LOW, 8'h10);
    repeat (2) token(RESP_STALL);
    rd_chk(OFS_CTRL_LOW, 8'h30, "ctrl_low");
    rd_chk(OFS_IRQ_STAT, 8'h02, "irq_stat");
    wr_reg(OFS_CTRL_LOW, 8'h00);
    rd_chk(OFS_CTRL_LOW, 8'h00, "ctrl_low");
    token(RESP_NAK);
    wr_reg(OFS_IRQ_STAT, 8'h0f);
    wr_reg(OFS_CTRL_LOW, 8'h40);
    // The pulse stands in the cycle after the write and is counted at its end
    @(posedge clk);
    #1 chk("clr_toggle", 8'h01, 8'(n_clr));
    wr_reg(OFS_CTRL_HIGH, 8'h80);
    wr_reg(OFS_CTRL_LOW, 8'h01);
    rd_chk(OFS_CTRL_LOW, 8'h02, "ctrl_low");
    rd_chk(OFS_IRQ_STAT, 8'h00, "irq_stat");
    wr_reg(OFS_CTRL_LOW, 8'h01);
    rd_chk(OFS_CTRL_LOW, 8'h03, "ctrl_low");
    wr_reg(OFS_CTRL_LOW, 8'h08);
    repeat (2) @(posedge clk);
    rd_chk(OFS_CTRL_LOW, 8'h02, "ctrl_low");
    chk("fifo_flush", 8'h01, 8'(n_flush));
    rd_chk(OFS_IRQ_STAT, 8'h08, "irq_stat");
    token(RESP_DATA);
    wait_hi(pkt_release, "pkt_release");
    rd_chk(OFS_CTRL_LOW, 8'h00, "ctrl_low");
    wr_reg(OFS_IRQ_STAT, 8'h0f);
    wr_reg(OFS_CTRL_HIGH, 8'h40);
    wr_reg(OFS_CTRL_LOW, 8'h10);
    token(RESP_ZLP);
    rd_chk(OFS_CTRL_LOW, 8'h14, "ctrl_low");
    wr_reg(OFS_CTRL_LOW, 8'h00);
    wr_reg(OFS_CTRL_HIGH, 8'h41);
    wr_reg(OFS_CTRL_LOW, 8'h01);
    rd_chk(OFS_CTRL_LOW, 8'h02, "ctrl_low");
    token(RESP_ZLP);
    @(posedge clk);
    sof_req <= 1'b1;
    @(posedge clk);
    sof_req <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(OFS_CTRL_LOW, 8'h07, "ctrl_low");
    token(RESP_DATA);
    wait_hi(pkt_release, "pkt_release");
    rd_chk(OFS_CTRL_LOW, 8'h04, "ctrl_low");
    conclude();
  end
endmodule
